// ---- hpc_port_config.sv ----
// Hub port configuration registers: charging enables, removable flags, port-in-use flags.
// Assumes byte register access from SMBus host or EEPROM loader, OTP values stable,
// strap and mode pins asynchronous.
//
// How it works
// - Bits 7:4 of the charging enable register are read-only and always read zero.
// - Override clear: removable and in-use fields are read-only OTP values.
// - With the override bit set, those fields accept EEPROM loads and SMBus writes.
// - One write setting the override bit and new removable flags applies both at once.
// - Removable bit n describes port n+1: one is removable, zero permanently attached.
// - Override clear: removable flags read as the inverse of the OTP non-removable bits.
// - Bits 6:4 of the removable register are read-only and always read zero.
// - In-use bit n enables port n+1 when one and marks it unused when zero.
// - A legacy-speed-only bit forces its USB2 side used regardless of the in-use bit.
// - SMBus mode takes SMBus host writes; I2C mode takes EEPROM loads instead.
`timescale 1ns/100ps
module hpc_port_config #(
   parameter int PORTS = hpc_pkg::PORT_COUNT
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             smbus_mode_pin,
   input  wire logic [3:0]       power_charge_strap_pins,
   input  wire hpc_pkg::hpc_otp_s otp_cfg,
   input  wire logic [3:0]       legacy_speed_only_bits,
   input  wire hpc_pkg::hpc_wr_s wr_req,
   input  wire hpc_pkg::hpc_rd_s rd_req,
   output logic      [7:0]       rd_data_q,
   output logic                  rd_valid_q,
   output logic      [3:0]       charge_enable_bits_q,
   output logic      [3:0]       port_removable_q,
   output logic      [3:0]       port_in_use_q,
   output logic      [3:0]       usb2_port_in_use_q,
   output logic                  removable_override_q
);

   typedef struct packed {
      logic [1:0] settle_cnt;
      logic       strap_taken;
      logic       override;
      logic [3:0] charge_en;
      logic [3:0] removable;
      logic [3:0] in_use;
      logic [3:0] removable_out;
      logic [3:0] in_use_out;
      logic [3:0] usb2_in_use;
      logic [7:0] rd_data;
      logic       rd_valid;
   } hpc_state_s;

   hpc_state_s state_q;
   hpc_state_s state_d;
   logic [4:0] pins_sync;
   logic       smbus_mode;
   logic [3:0] strap_sync;
   logic       wr_allowed;
   logic [3:0] removable_eff;
   logic [3:0] in_use_eff;
   logic [3:0] usb2_eff;

   // Field layout is fixed at four ports
   if (PORTS != hpc_pkg::PORT_COUNT) begin : g_bad_ports
      $error("hpc_port_config: only four ports fit the fields");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   hpc_pin_sync #(
      .WIDTH (5)
   ) u_pin_sync (
      .clock      (clock),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .pin_async  ({smbus_mode_pin, power_charge_strap_pins}),
      .pin_sync_q (pins_sync)
   );

   assign smbus_mode = pins_sync[4];
   assign strap_sync = pins_sync[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // Source gating by mode pin and write source
   always_comb begin
      // Only the source matching the mode pin may write
      wr_allowed = wr_req.en && (smbus_mode != wr_req.eeprom_src);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective field values, one slice per port
   // Clear override shows OTP; the shadows track it so in-use starts there when override is set
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      assign removable_eff[p] = state_q.override ? state_q.removable[p]
                                                 : ~otp_cfg.non_removable[p];
      assign in_use_eff[p]    = state_q.override ? state_q.in_use[p]
                                                 : otp_cfg.in_use[p];
      // Legacy-speed port stays on for USB2 even when marked unused
      assign usb2_eff[p]      = in_use_eff[p] | legacy_speed_only_bits[p];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_d = state_q;
      if (clk_en) begin
         state_d.rd_valid = 1'b0;

         // Strap level is valid only once the sync chain has filled after release
         if (!state_q.strap_taken) begin
            if (state_q.settle_cnt == hpc_pkg::STRAP_SETTLE_CYCLES) begin
               state_d.charge_en   = strap_sync;
               state_d.strap_taken = 1'b1;
            end else begin
               state_d.settle_cnt = state_q.settle_cnt + 2'h1;
            end
         end

         // Shadows follow OTP while override is clear
         if (!state_q.override) begin
            state_d.removable = ~otp_cfg.non_removable;
            state_d.in_use    = otp_cfg.in_use;
         end

         if (wr_allowed) begin
            case (wr_req.addr)
               hpc_pkg::CHARGE_PORT_ENABLE_OFS: begin
                  // A write before strap capture is superseded by the strap
                  state_d.charge_en = wr_req.data[3:0];
               end
               hpc_pkg::PORT_REMOVABLE_CONFIG_OFS: begin
                  state_d.override = wr_req.data[hpc_pkg::OVERRIDE_BIT];
                  // New override value counts for the same byte
                  if (wr_req.data[hpc_pkg::OVERRIDE_BIT] || state_q.override) begin
                     state_d.removable = wr_req.data[3:0];
                  end
               end
               hpc_pkg::PORT_IN_USE_CONFIG_OFS: begin
                  // Ports 1 and 3 both off is not checked; the writer must avoid it
                  if (state_q.override) begin
                     state_d.in_use = wr_req.data[3:0];
                  end
               end
               default: begin
                  state_d.override = state_q.override;
               end
            endcase
         end

         state_d.removable_out = removable_eff;
         state_d.in_use_out    = in_use_eff;
         state_d.usb2_in_use   = usb2_eff;

         if (rd_req.en) begin
            state_d.rd_valid = 1'b1;
            case (rd_req.addr)
               hpc_pkg::CHARGE_PORT_ENABLE_OFS: begin
                  state_d.rd_data = {4'h0, state_q.charge_en};
               end
               hpc_pkg::PORT_REMOVABLE_CONFIG_OFS: begin
                  state_d.rd_data = {state_q.override, 3'h0, removable_eff};
               end
               hpc_pkg::PORT_IN_USE_CONFIG_OFS: begin
                  state_d.rd_data = {4'h0, in_use_eff};
               end
               default: begin
                  state_d.rd_data = hpc_pkg::READ_ZERO;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q               <= '0;
         state_q.charge_en     <= hpc_pkg::CHARGE_ENABLE_RESET;
         state_q.removable     <= hpc_pkg::REMOVABLE_RESET;
         state_q.in_use        <= hpc_pkg::PORT_IN_USE_RESET;
         state_q.in_use_out    <= hpc_pkg::PORT_IN_USE_RESET;
         state_q.usb2_in_use   <= hpc_pkg::PORT_IN_USE_RESET;
         state_q.rd_data       <= hpc_pkg::READ_ZERO;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign rd_data_q            = state_q.rd_data;
   assign rd_valid_q           = state_q.rd_valid;
   assign charge_enable_bits_q = state_q.charge_en;
   assign port_removable_q     = state_q.removable_out;
   assign port_in_use_q        = state_q.in_use_out;
   assign usb2_port_in_use_q   = state_q.usb2_in_use;
   assign removable_override_q = state_q.override;

endmodule : hpc_port_config

// ---- hpc_pkg.sv ----
// Package for the hub port configuration register bank.
// Assumes one 250 MHz clock and byte-wide register access from an SMBus host or EEPROM loader.
package hpc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CHARGE_PORT_ENABLE_OFS    = 8'h06;
   localparam logic [7:0] PORT_REMOVABLE_CONFIG_OFS = 8'h07;
   localparam logic [7:0] PORT_IN_USE_CONFIG_OFS    = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int         PORT_COUNT            = 4;
   localparam int         OVERRIDE_BIT          = 7;
   localparam logic [3:0] CHARGE_ENABLE_RESET   = 4'h0;
   localparam logic [3:0] PORT_IN_USE_RESET     = 4'hf;
   localparam logic [3:0] REMOVABLE_RESET       = 4'h0;
   localparam logic [7:0] READ_ZERO             = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: two sync stages, then the strap level is valid
   localparam int         SYNC_STAGES           = 2;
   localparam logic [1:0] STRAP_SETTLE_CYCLES   = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic       en;
      logic       eeprom_src;
      logic [7:0] addr;
      logic [7:0] data;
   } hpc_wr_s;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
   } hpc_rd_s;

   typedef struct packed {
      logic [3:0] non_removable;
      logic [3:0] in_use;
   } hpc_otp_s;

endpackage : hpc_pkg

// ---- hpc_pin_sync.sv ----
// Two-stage synchroniser for asynchronous level pins.
// Assumes inputs are slow levels; the first stage feeds only the second.
`timescale 1ns/100ps
module hpc_pin_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_sync_q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } hpc_sync_state_s;

   hpc_sync_state_s state_q;
   hpc_sync_state_s state_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("hpc_pin_sync: WIDTH must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      if (clk_en) begin
         state_d.meta   = pin_async;
         state_d.stable = state_q.meta;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign pin_sync_q = state_q.stable;

endmodule : hpc_pin_sync

// ---- hpc_port_config_chk.sv ----
// Checker for the port configuration register bank.
// Assumes clk_en high and a static OTP image.
`timescale 1ns/100ps
module hpc_port_config_chk (
   input wire logic              clock,
   input wire logic              reset_n,
   input wire logic              smbus_mode_pin,
   input wire logic [3:0]        legacy_speed_only_bits,
   input wire hpc_pkg::hpc_otp_s otp_cfg,
   input wire hpc_pkg::hpc_wr_s  wr_req,
   input wire hpc_pkg::hpc_rd_s  rd_req,
   input wire logic [7:0]        rd_data_q,
   input wire logic              rd_valid_q,
   input wire logic [3:0]        port_removable_q,
   input wire logic [3:0]        port_in_use_q,
   input wire logic [3:0]        usb2_port_in_use_q,
   input wire logic              removable_override_q
);
   logic [3:0] mode_q;
   logic       ok_w;
   logic       bad_w;
   // Mode judged only once steady past the synchroniser
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         mode_q <= 4'h0;
      else
         mode_q <= {mode_q[2:0], smbus_mode_pin};
   end
   assign ok_w  = wr_req.en && (mode_q == 4'hf ? !wr_req.eeprom_src
                  : (mode_q == 4'h0 && wr_req.eeprom_src));
   assign bad_w = wr_req.en && mode_q == 4'hf && wr_req.eeprom_src;
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_rsvd_charge: assert property (
      rd_req.en && rd_req.addr == 8'h06 |=> rd_data_q[7:4] == 4'h0)
      else $error("charge register upper bits not zero");
   a_rsvd_rmbl: assert property (
      rd_req.en && rd_req.addr == 8'h07 |=> rd_data_q[6:4] == 3'h0)
      else $error("removable register reserved bits not zero");
   a_rd_pulse: assert property (1'b1 |=> rd_valid_q == $past(rd_req.en))
      else $error("read valid not one cycle after request");
   a_otp_rmbl: assert property (
      !removable_override_q [*3] |-> port_removable_q == ~otp_cfg.non_removable)
      else $error("removable flags not inverse of otp");
   a_otp_used: assert property (
      !removable_override_q [*3] |-> port_in_use_q == otp_cfg.in_use)
      else $error("in use flags not from otp");
   a_usb2_force: assert property (
      1'b1 |=> (usb2_port_in_use_q & $past(legacy_speed_only_bits))
               == $past(legacy_speed_only_bits))
      else $error("legacy port not forced in use");
   a_rmbl_write: assert property (
      ok_w && wr_req.addr == 8'h07 && wr_req.data[7]
      |=> removable_override_q ##1 port_removable_q == $past(wr_req.data[3:0], 2))
      else $error("override and flags not applied together");
   a_used_write: assert property (
      ok_w && wr_req.addr == 8'h08 && removable_override_q
      |=> ##1 port_in_use_q == $past(wr_req.data[3:0], 2))
      else $error("in use write not applied");
   a_wrong_src: assert property (bad_w |=> $stable(removable_override_q))
      else $error("write from wrong source taken");
endmodule : hpc_port_config_chk

bind hpc_port_config hpc_port_config_chk u_chk (.clock, .reset_n, .smbus_mode_pin,
   .legacy_speed_only_bits, .otp_cfg, .wr_req, .rd_req, .rd_data_q, .rd_valid_q,
   .port_removable_q, .port_in_use_q, .usb2_port_in_use_q, .removable_override_q);

// ---- hpc_cfg_host.sv ----
// Host model: SMBus host or EEPROM loader, one byte per request.
// Assumes its tasks are called from one bench process.
`timescale 1ns/100ps
module hpc_cfg_host (
   input  wire logic       clock,
   input  wire logic       smbus_mode,
   input  wire logic [7:0] rd_data_q,
   input  wire logic       rd_valid_q,
   output hpc_pkg::hpc_wr_s wr_req,
   output hpc_pkg::hpc_rd_s rd_req
);
   initial begin
      wr_req = '0;
      rd_req = '0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d, input logic bad);
      logic [7:0] v;
      v = d;
      if (a == 8'h08 && v[0] == 1'b0 && v[2] == 1'b0)
         v[0] = 1'b1;
      @(posedge clock);
      wr_req <= '{1'b1, smbus_mode == bad, a, v};
      @(posedge clock);
      // Released lines show the inverse, not the last value
      wr_req <= '{1'b0, 1'b0, ~a, ~v};
   endtask : write_byte
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clock);
      rd_req <= '{1'b1, a};
      @(posedge clock);
      rd_req <= '{1'b0, ~a};
      for (int i = 0; i < 4; i++) begin
         #1;
         if (rd_valid_q === 1'b1) begin
            d = rd_data_q;
            break;
         end
         @(posedge clock);
      end
   endtask : read_byte
endmodule : hpc_cfg_host

// ---- tb.sv ----
// Self-checking bench for the port configuration register bank.
// Assumes a static OTP image; the host model makes all register requests.
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic [7:0] wa, wd, ra, rd;
      logic [3:0] rm, pu;
   } hpc_row_s;
   logic              clock = 1'b0;
   logic              reset_n = 1'b0;
   logic              clk_en = 1'b1;
   logic              smbus_mode_pin = 1'b1;
   logic [3:0]        strap = 4'ha;
   logic [3:0]        legacy = 4'h2;
   hpc_pkg::hpc_otp_s otp = '{4'h3, 4'hd};
   hpc_pkg::hpc_wr_s  wr_req;
   hpc_pkg::hpc_rd_s  rd_req;
   logic [7:0]        rd_data_q, d;
   logic              rd_valid_q, removable_override_q;
   logic [3:0]        charge_q, rm_q, pu_q, u2_q;
   int                n_fail = 0, comparisons = 0;
   hpc_row_s rows [8] = '{
      '{8'h00, 8'hff, 8'h06, 8'h0a, 4'hc, 4'hd},
      '{8'h06, 8'hff, 8'h06, 8'h0f, 4'hc, 4'hd},
      '{8'h07, 8'h05, 8'h07, 8'h0c, 4'hc, 4'hd},
      '{8'h08, 8'h00, 8'h08, 8'h0d, 4'hc, 4'hd},
      '{8'h07, 8'hf5, 8'h07, 8'h85, 4'h5, 4'hd},
      '{8'h08, 8'h6e, 8'h08, 8'h0e, 4'h5, 4'he},
      '{8'h07, 8'h00, 8'h07, 8'h0c, 4'hc, 4'hd},
      '{8'h09, 8'h00, 8'h09, 8'h00, 4'hc, 4'hd}};
   hpc_port_config u_dut (.clock, .reset_n, .clk_en, .smbus_mode_pin,
      .power_charge_strap_pins(strap), .otp_cfg(otp), .legacy_speed_only_bits(legacy),
      .wr_req, .rd_req, .rd_data_q, .rd_valid_q, .charge_enable_bits_q(charge_q),
      .port_removable_q(rm_q), .port_in_use_q(pu_q), .usb2_port_in_use_q(u2_q),
      .removable_override_q);
   hpc_cfg_host u_host (.clock, .smbus_mode(smbus_mode_pin), .rd_data_q, .rd_valid_q,
      .wr_req, .rd_req);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, e, s);
      end
   endtask : chk
   task automatic finish_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   initial begin
      forever #2 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clock);
      #1;
      chk("reset in use", 8'h0f, {4'h0, pu_q});
      @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      foreach (rows[i]) begin
         u_host.write_byte(rows[i].wa, rows[i].wd, 1'b0);
         u_host.read_byte(rows[i].ra, d);
         chk("read data", rows[i].rd, d);
         chk("removable", {4'h0, rows[i].rm}, {4'h0, rm_q});
         chk("in use", {4'h0, rows[i].pu}, {4'h0, pu_q});
         chk("usb2 in use", {4'h0, rows[i].pu | legacy}, {4'h0, u2_q});
      end
      // Awkward cases: wrong source, EEPROM load, reset in mid-run
      u_host.write_byte(8'h07, 8'h85, 1'b1);
      u_host.read_byte(8'h07, d);
      chk("wrong source", 8'h0c, d);
      @(posedge clock);
      smbus_mode_pin <= 1'b0;
      repeat (4) @(posedge clock);
      u_host.write_byte(8'h07, 8'h8a, 1'b0);
      u_host.read_byte(8'h07, d);
      chk("eeprom load", 8'h8a, d);
      chk("eeprom flags", 8'h0a, {4'h0, rm_q});
      chk("override", 8'h01, {7'h00, removable_override_q});
      @(posedge clock);
      strap <= 4'h5;
      reset_n <= 1'b0;
      @(posedge clock);
      #1;
      chk("reset flags", 8'h00, {rm_q, charge_q});
      chk("reset usb2", 8'h0f, {4'h0, u2_q});
      @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      u_host.read_byte(8'h06, d);
      chk("strap load", 8'h05, d);
      chk("charge pins", 8'h05, {4'h0, charge_q});
      // A write while the clock enable is low must be lost
      @(posedge clock);
      clk_en <= 1'b0;
      u_host.write_byte(8'h06, 8'h0f, 1'b0);
      clk_en <= 1'b1;
      u_host.read_byte(8'h06, d);
      chk("frozen charge", 8'h05, d);
      finish_test();
   end
endmodule : tb
